// File: core/ctp_axil_slave.sv
`timescale 1ns/100ps
`include "ctp_params.svh"

module ctp_axil_slave
  import ctp_pkg::*;
#(
  parameter int AW = 10
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels.
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels.
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side.
  output ctp_wr_type wr,
  output logic [7:0] rd_index,
  input wire logic [7:0] rd_byte
);

  logic aw_full;
  logic w_full;
  logic [AW-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic rd_pend;

  // ==========================================================
  // Write address and data are held until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      wr <= '0;
    end else begin
      wr.en <= 1'b0;
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wready <= 1'b0;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (aw_full && w_full && !bvalid) begin
        wr <= '{en: 1'b1, index: aw_addr[`CTP_ADDR_LSB +: 8], data: w_byte, strb: w_lane};
        bvalid <= 1'b1;
        bresp <= 2'h0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Reads answer one edge after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_index <= 8'h00;
      rd_pend <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rd_index <= araddr[`CTP_ADDR_LSB +: 8];
        rd_pend <= 1'b1;
      end
      if (rd_pend) begin
        rdata <= {24'h0, rd_byte};
        rvalid <= 1'b1;
        rd_pend <= 1'b0;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // ctp_axil_slave

// File: core/ctp_params.svh
`ifndef CTP_PARAMS_SVH
`define CTP_PARAMS_SVH

// ==========================================================
// Register indices; the byte address is four times the index.
`define CTP_IDX_LOW_DUTY 8'h28
`define CTP_IDX_HIGH_DUTY 8'h29
`define CTP_IDX_UPPER_MODE 8'h2a
`define CTP_IDX_PAIR_CTRL 8'h2b
`define CTP_IDX_STATUS 8'h2c
`define CTP_ADDR_LSB 2

// ==========================================================
// Reset values.
`define CTP_DUTY_RESET 8'hff
`define CTP_MODE_RESET 8'h00
`define CTP_CTRL_RESET 8'h00

// ==========================================================
// Field positions.
`define CTP_BIT_INIT 0
`define CTP_BIT_BUFEN 1
`define CTP_BIT_EXTCLK 2
`define CTP_MODE_LSB 3
`define CTP_CKSEL_LSB 5
`define CTP_BIT_RUN 0
`define CTP_BIT_CASCADE 1
`define CTP_MODE_PWM12 2'h2

// ==========================================================
// Counting limits.
`define CTP_CNT_LAST 8'hff
`define CTP_FRAME_LAST 4'hf
`define CTP_DIV_W 11

`endif

// File: core/ctp_pkg.sv
package ctp_pkg;

  // ==========================================================
  // Register write carried from the bus slave.
  typedef struct packed {
    logic en;
    logic [7:0] index;
    logic [7:0] data;
    logic strb;
  } ctp_wr_type;

  // ==========================================================
  // Twelve-bit duty setting.
  typedef struct packed {
    logic [7:0] duty;
    logic [3:0] extra;
  } ctp_duty_type;

  // ==========================================================
  // Output phase within one cycle.
  typedef enum logic [1:0] {
    CTP_STOP = 2'b00,
    CTP_WAIT = 2'b01,
    CTP_DRIVE = 2'b10
  } ctp_phase_type;

endpackage

// File: core/ctp_pwm.sv
// Contract
// RULE_01 - Extra bits stretch frame cycles 9; 5,13; 3,7,11,15; all even cycles.
// RULE_02 - Initial-level bit picks the pin's idle level, 0 low, 1 high.
// RULE_03 - While stopped the pin shows the initial-level bit.
// RULE_04 - Run bit set makes the counter step once per source tick.
// RULE_05 - Counter equal to duty value flips the pin away from idle.
// RULE_06 - Stretched cycles flip at duty plus one, one tick longer idle.
// RULE_07 - All extra bits zero means no cycle is stretched.
// RULE_08 - Count 256 wraps to zero and returns the pin to idle.
// RULE_09 - Every wrap pulses the cycle interrupt.
// RULE_10 - Every sixteenth wrap pulses the frame interrupt.
// RULE_11 - Clearing run stops, zeroes the counter and restores idle level.
// RULE_12 - External clock enters on the input pin, slow enough, wide levels.
// RULE_13 - Buffer-enable bit 0 disables, 1 enables duty buffering.
// RULE_14 - Buffered running writes wait until the frame end, then load.
// RULE_15 - Buffered reads return the last written buffer contents.
// RULE_16 - Writes while stopped load the active value at once.
// RULE_17 - Software writes low then high; high write commits both.
// RULE_18 - Unbuffered running writes act at once; passed values wait a wrap.
// RULE_19 - Unbuffered value equal to count matches right after the write.
// RULE_20 - Software should buffer when off-grid edges are unacceptable.
// RULE_21 - Low reg holds duty 7..4 and extra bits; high holds duty 3..0.
// RULE_22 - Mode acts only with cascade set and upper mode field 10.
// RULE_23 - A four-bit frame index steps on each wrap.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ctp_params.svh"

module ctp_pwm
  import ctp_pkg::*;
#(
  parameter int AW = 10
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pins.
  input wire logic timer_input_pin,
  output logic pwm_output_pin,
  // Events.
  output logic cycle_irq,
  output logic frame_irq
);

  ctp_wr_type wr;
  logic [7:0] rd_index;
  logic [7:0] rd_byte;
  logic [7:0] low_duty_reg;
  logic [7:0] high_duty_reg;
  logic [7:0] upper_mode_reg;
  logic [7:0] pair_control_reg;
  ctp_duty_type buf_duty;
  ctp_duty_type act_duty;
  ctp_phase_type phase;
  ctp_phase_type next_phase;
  logic [7:0] count;
  logic [3:0] frame_idx;
  logic [`CTP_DIV_W-1:0] prescale;
  logic sync1;
  logic sync2;
  logic sync3;
  logic ext_level;

  // ==========================================================
  // Bus slave.
  ctp_axil_slave #(.AW(AW)) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .rd_index(rd_index),
    .rd_byte(rd_byte)
  );

  // ==========================================================
  // Functions.
  function automatic logic wr_hit(input ctp_wr_type w, input logic [7:0] idx);
    return w.en && w.strb && (w.index == idx);
  endfunction

  function automatic logic [`CTP_DIV_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: div_mask = 11'h7ff;
      3'h1: div_mask = 11'h3ff;
      3'h2: div_mask = 11'h0ff;
      3'h3: div_mask = 11'h03f;
      3'h4: div_mask = 11'h00f;
      3'h5: div_mask = 11'h003;
      3'h6: div_mask = 11'h001;
      default: div_mask = 11'h000;
    endcase
  endfunction

  // Frame index n stands for cycle n plus one.
  function automatic logic is_stretched(input logic [3:0] ad, input logic [3:0] idx);
    return (ad[0] && idx == 4'h8) || // RULE_01
      (ad[1] && idx[2:0] == 3'h4) ||
      (ad[2] && idx[1:0] == 2'h2) ||
      (ad[3] && idx[0]);
  endfunction

  // ==========================================================
  // Decoding.
  wire init_level_bit = upper_mode_reg[`CTP_BIT_INIT]; // RULE_02
  wire buffer_enable_bit = upper_mode_reg[`CTP_BIT_BUFEN]; // RULE_13
  wire ext_clock_sel = upper_mode_reg[`CTP_BIT_EXTCLK];
  wire [1:0] upper_mode_field = upper_mode_reg[`CTP_MODE_LSB +: 2];
  wire [2:0] clock_sel = upper_mode_reg[`CTP_CKSEL_LSB +: 3];
  wire upper_run_bit = pair_control_reg[`CTP_BIT_RUN];
  wire cascade_bit = pair_control_reg[`CTP_BIT_CASCADE];
  wire mode_ok = cascade_bit && (upper_mode_field == `CTP_MODE_PWM12); // RULE_22
  wire running = upper_run_bit && mode_ok;
  wire wr_low = wr_hit(wr, `CTP_IDX_LOW_DUTY);
  wire wr_high = wr_hit(wr, `CTP_IDX_HIGH_DUTY);
  wire wr_mode = wr_hit(wr, `CTP_IDX_UPPER_MODE);
  wire wr_ctrl = wr_hit(wr, `CTP_IDX_PAIR_CTRL);
  wire hold_in_buffer = running && buffer_enable_bit; // RULE_14
  wire int_tick = &(prescale | ~div_mask(clock_sel));
  wire ext_fall = (sync2 == sync3) && !sync3 && ext_level; // RULE_12
  wire tick = running && (ext_clock_sel ? ext_fall : int_tick); // RULE_04
  wire overflow = tick && (count == `CTP_CNT_LAST); // RULE_08
  wire frame_end = overflow && (frame_idx == `CTP_FRAME_LAST); // RULE_10
  wire stretch = is_stretched(act_duty.extra, frame_idx); // RULE_06 RULE_07
  wire [8:0] target = {1'b0, act_duty.duty} + {8'h00, stretch};
  wire match = ({1'b0, count} == target); // RULE_05 RULE_19
  wire [7:0] status = {2'b00, pwm_output_pin, running, frame_idx};
  // A high write joins the held low byte with the new nibble.
  wire ctp_duty_type new_duty = '{duty: {low_duty_reg[7:4], wr.data[3:0]}, extra: low_duty_reg[3:0]}; // RULE_21

  assign rd_byte = (rd_index == `CTP_IDX_LOW_DUTY) ? low_duty_reg : // RULE_15
    (rd_index == `CTP_IDX_HIGH_DUTY) ? high_duty_reg :
    (rd_index == `CTP_IDX_UPPER_MODE) ? upper_mode_reg :
    (rd_index == `CTP_IDX_PAIR_CTRL) ? pair_control_reg :
    (rd_index == `CTP_IDX_STATUS) ? status : 8'h00;

  // ==========================================================
  // Registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_duty_reg <= `CTP_DUTY_RESET;
      high_duty_reg <= `CTP_DUTY_RESET;
      upper_mode_reg <= `CTP_MODE_RESET;
      pair_control_reg <= `CTP_CTRL_RESET;
    end else begin
      if (wr_low) begin
        low_duty_reg <= wr.data;
      end
      if (wr_high) begin
        high_duty_reg <= wr.data;
      end
      if (wr_mode && !upper_run_bit) begin
        upper_mode_reg <= wr.data;
      end
      if (wr_ctrl) begin
        pair_control_reg <= wr.data;
      end
    end
  end

  // ==========================================================
  // Duty buffer and active value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_duty <= '1;
      act_duty <= '1;
    end else begin
      if (wr_high && buffer_enable_bit) begin
        buf_duty <= new_duty; // RULE_17
      end
      if (wr_high && !hold_in_buffer) begin
        act_duty <= new_duty; // RULE_16 RULE_18
      end else if (frame_end && buffer_enable_bit) begin
        act_duty <= buf_duty; // RULE_14
      end
    end
  end

  // ==========================================================
  // Source clock: divider and external pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= '0;
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      ext_level <= 1'b1;
    end else begin
      prescale <= running ? prescale + 1'b1 : '0;
      sync1 <= timer_input_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        ext_level <= sync3;
      end
    end
  end

  // ==========================================================
  // Counter and frame index.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
      frame_idx <= 4'h0;
    end else if (!running) begin
      count <= 8'h00; // RULE_11
      frame_idx <= 4'h0;
    end else begin
      if (tick) begin
        count <= count + 8'h01; // RULE_04 RULE_08
      end
      if (overflow) begin
        frame_idx <= frame_idx + 4'h1; // RULE_23
      end
    end
  end

  // ==========================================================
  // Output phase.
  always_comb begin
    case (phase)
      CTP_STOP: next_phase = running ? CTP_WAIT : CTP_STOP;
      CTP_WAIT: begin
        if (!running) begin
          next_phase = CTP_STOP; // RULE_11
        end else if (overflow) begin
          next_phase = CTP_WAIT;
        end else if (match) begin
          next_phase = CTP_DRIVE; // RULE_05
        end else begin
          next_phase = CTP_WAIT;
        end
      end
      CTP_DRIVE: begin
        if (!running) begin
          next_phase = CTP_STOP;
        end else if (overflow) begin
          next_phase = CTP_WAIT; // RULE_08
        end else begin
          next_phase = CTP_DRIVE;
        end
      end
      default: next_phase = CTP_STOP;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= CTP_STOP;
      pwm_output_pin <= 1'b0;
      cycle_irq <= 1'b0;
      frame_irq <= 1'b0;
    end else begin
      phase <= next_phase;
      pwm_output_pin <= init_level_bit ^ (next_phase == CTP_DRIVE); // RULE_02 RULE_03
      cycle_irq <= overflow; // RULE_09
      frame_irq <= frame_end; // RULE_10
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_frame_end;
    overflow && frame_idx == `CTP_FRAME_LAST;
  endsequence

  sequence s_frame_irqs;
    cycle_irq && frame_irq;
  endsequence

  chk_stop_level: assert property ( // RULE_03
    !running |=> pwm_output_pin == $past(init_level_bit) && count == 8'h00)
    else $error("Stopped timer does not show the idle level.");

  chk_count_step: assert property ( // RULE_04
    tick && count != `CTP_CNT_LAST |=> count == $past(count) + 8'h01)
    else $error("Counter did not step on a source tick.");

  chk_no_step: assert property ( // RULE_04
    running && !tick |=> count == $past(count))
    else $error("Counter moved without a source tick.");

  chk_match_flip: assert property ( // RULE_05
    phase == CTP_WAIT && running && !overflow && target == {1'b0, count}
    |=> pwm_output_pin == !$past(init_level_bit))
    else $error("Duty match did not flip the pin.");

  chk_stretch_delay: assert property ( // RULE_06
    phase == CTP_WAIT && running && !overflow && stretch && count == act_duty.duty
    |=> pwm_output_pin == $past(init_level_bit))
    else $error("Stretched cycle flipped at the plain duty value.");

  chk_no_stretch: assert property ( // RULE_07
    act_duty.extra == 4'h0 |-> !stretch)
    else $error("Cycle stretched with no extra bits set.");

  chk_wrap_idle: assert property ( // RULE_08
    overflow && running |=> count == 8'h00 && pwm_output_pin == $past(init_level_bit))
    else $error("Wrap did not clear the counter or restore idle.");

  chk_cycle_irq: assert property ( // RULE_09
    overflow |=> cycle_irq)
    else $error("Wrap without a cycle interrupt.");

  chk_frame_irq: assert property ( // RULE_10
    s_frame_end |=> s_frame_irqs)
    else $error("Sixteenth wrap without a frame interrupt.");

  chk_frame_only: assert property ( // RULE_10
    frame_irq |-> $past(frame_idx) == `CTP_FRAME_LAST)
    else $error("Frame interrupt at the wrong wrap.");

  chk_buf_hold: assert property ( // RULE_14
    hold_in_buffer && !frame_end |=> act_duty == $past(act_duty))
    else $error("Buffered active duty changed mid frame.");

  chk_frame_load: assert property ( // RULE_14
    s_frame_end ##0 buffer_enable_bit && !wr_high |=> act_duty == $past(buf_duty))
    else $error("Buffer not loaded at the frame end.");

  chk_direct_load: assert property ( // RULE_16
    wr_high && !hold_in_buffer |=> act_duty == $past(new_duty))
    else $error("Direct duty write did not take effect.");

  chk_mode_gate: assert property ( // RULE_22
    !mode_ok |-> !running ##1 phase == CTP_STOP)
    else $error("Timer ran outside the twelve-bit mode.");

endmodule // ctp_pwm

// File: tb/test_ctp_pwm.sv
`timescale 1ns/100ps
`include "ctp_params.svh"

module test_ctp_pwm;
  // ==========================================================
  // Signals.
  localparam logic [7:0] LOW = `CTP_IDX_LOW_DUTY;
  localparam logic [7:0] HIGH = `CTP_IDX_HIGH_DUTY;
  localparam logic [7:0] MODE = `CTP_IDX_UPPER_MODE;
  localparam logic [7:0] CTRL = `CTP_IDX_PAIR_CTRL;
  localparam logic [7:0] STAT = `CTP_IDX_STATUS;
  localparam logic [7:0] MODE_PWM = {3'h7, `CTP_MODE_PWM12, 3'h0};
  logic aclk = 1'b0;
  logic aresetn;
  logic [9:0] awaddr;
  logic [9:0] araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, ext_on;
  logic tin = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, pin, cyc_irq, frm_irq;
  wire logic [31:0] rdata;
  int error_cnt = 0;
  int n_checks = 0;
  int tdiv = 0;

  always #5 aclk = ~aclk;

  ctp_pwm #(.AW(10)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(), .rvalid(rvalid), .rready(rready),
    .timer_input_pin(tin), .pwm_output_pin(pin),
    .cycle_irq(cyc_irq), .frame_irq(frm_irq)
  );

  // ==========================================================
  // External source clock, four cycles per level.
  always @(posedge aclk) begin
    if (ext_on) begin
      tdiv <= tdiv + 1;
      if (tdiv % 4 == 3) tin <= ~tin;
    end
  end

  // ==========================================================
  // Comparisons and verdict.
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus cycles.
  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if ((awvalid && awready) === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if ((wvalid && wready) === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask

  task automatic axr(input logic [7:0] idx, output logic [7:0] d);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while ((arvalid && arready) !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
  endtask

  task automatic set_duty(input logic [7:0] d, input logic [3:0] e);
    axw(LOW, {d[7:4], e});
    axw(HIGH, {4'h0, d[3:0]});
  endtask

  task automatic run(input logic [7:0] m, input logic [7:0] d, input logic [3:0] e);
    axw(CTRL, 8'h00);
    axw(MODE, m);
    set_duty(d, e);
    axw(CTRL, 8'h03);
  endtask

  task automatic frame_sync();
    do @(posedge aclk); while (frm_irq !== 1'b1);
  endtask

  // Counts one output cycle up to the next cycle interrupt.
  // The pin is registered, so it leaves idle one clock after the duty match.
  task automatic meas(output int diff, output int len, output logic fr, input logic lvl);
    diff = 0;
    len = 0;
    fr = 1'b0;
    do begin
      @(posedge aclk);
      len++;
      if (pin !== lvl) diff++;
      if (frm_irq === 1'b1) fr = 1'b1;
    end while (cyc_irq !== 1'b1);
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_reset();
    logic [7:0] b;
    chk_bit(pin, 1'b0);
    for (int i = 0; i < 6; i++) begin
      axr(LOW + i[7:0], b);
      chk_byte(b, (i < 2) ? 8'hff : 8'h00);
    end
  endtask

  task automatic t_idle();
    axw(MODE, MODE_PWM | 8'h01);
    repeat (3) @(posedge aclk);
    chk_bit(pin, 1'b1);
    axw(MODE, MODE_PWM);
    repeat (3) @(posedge aclk);
    chk_bit(pin, 1'b0);
  endtask

  task automatic t_frame(input logic [3:0] e, input logic lvl);
    int diff, len, s;
    logic fr;
    logic [7:0] b;
    run(MODE_PWM | {7'h0, lvl}, 8'h65, e);
    frame_sync();
    for (int k = 1; k <= 16; k++) begin
      meas(diff, len, fr, lvl);
      s = (e[0] && k == 9) || (e[1] && k % 8 == 5) || (e[2] && k % 4 == 3) || (e[3] && k % 2 == 0);
      chk_cnt(len, 256);
      chk_cnt(diff, 154 - s);
      chk_bit(fr, k == 16);
    end
    axw(CTRL, 8'h00);
    axr(STAT, b);
    chk_byte(b, {2'b00, lvl, 5'h00});
    chk_bit(pin, lvl);
  endtask

  task automatic t_buf();
    int diff, len;
    logic fr;
    logic [7:0] b;
    run(MODE_PWM | 8'h02, 8'h40, 4'h0);
    frame_sync();
    set_duty(8'ha0, 4'h0);
    axr(LOW, b);
    chk_byte(b, 8'ha0);
    meas(diff, len, fr, 1'b0);
    meas(diff, len, fr, 1'b0);
    chk_cnt(diff, 255 - 8'h40);
    frame_sync();
    meas(diff, len, fr, 1'b0);
    chk_cnt(diff, 255 - 8'ha0);
  endtask

  task automatic t_unbuf();
    int diff, len;
    logic fr;
    run(MODE_PWM, 8'hc0, 4'h0);
    meas(diff, len, fr, 1'b0);
    repeat (100) @(posedge aclk);
    set_duty(8'h10, 4'h0);
    meas(diff, len, fr, 1'b0);
    chk_cnt(diff, 0);
    meas(diff, len, fr, 1'b0);
    chk_cnt(diff, 255 - 8'h10);
  endtask

  task automatic t_ext();
    int diff, len;
    logic fr;
    ext_on <= 1'b1;
    run(MODE_PWM | 8'h04, 8'h80, 4'h0);
    meas(diff, len, fr, 1'b0);
    meas(diff, len, fr, 1'b0);
    chk_cnt(len, 2048);
    chk_cnt(diff, 1023);
    axw(CTRL, 8'h00);
    ext_on <= 1'b0;
  endtask

  task automatic t_div();
    int diff, len;
    logic fr;
    run(8'hd0, 8'h80, 4'h0);
    meas(diff, len, fr, 1'b0);
    meas(diff, len, fr, 1'b0);
    chk_cnt(len, 512);
    chk_cnt(diff, 255);
    axw(CTRL, 8'h00);
  endtask

  task automatic t_gate();
    logic [7:0] b;
    run(MODE_PWM, 8'h01, 4'h0);
    axw(CTRL, 8'h01);
    repeat (20) @(posedge aclk);
    axr(STAT, b);
    chk_byte(b, 8'h00);
    run(8'he8, 8'h01, 4'h0);
    repeat (20) @(posedge aclk);
    axr(STAT, b);
    chk_byte(b, 8'h00);
    axw(CTRL, 8'h00);
  endtask

  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0;
    wstrb = 4'h1;
    ext_on = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_idle();
    t_frame(4'h1, 1'b0);
    t_frame(4'h2, 1'b0);
    t_frame(4'h4, 1'b1);
    t_frame(4'h8, 1'b0);
    t_frame(4'h0, 1'b1);
    t_buf();
    t_unbuf();
    t_ext();
    t_div();
    t_gate();
    results();
  end

  initial begin
    repeat (80000) @(posedge aclk);
    error_cnt++;
    results();
  end
endmodule // test_ctp_pwm
